// File: include/flsr_pkg.sv
// Shared constants and types for the fuse, lock and signature readout path
package flsr_pkg;
    // Core clock and self-timed programming window
    localparam int CLK_PERIOD_NS    = 50;
    localparam int PROG_TIME_MIN_US = 3700;
    localparam int PROG_TIME_MAX_US = 4500;
    localparam int PROG_CYC_MIN     = (PROG_TIME_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CYC_MAX     = (PROG_TIME_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int TIMER_W          = 17;
    // Instruction windows after arming, in cycles
    localparam logic [2:0] LPM_WINDOW = 3'h3;
    localparam logic [2:0] SPM_WINDOW = 3'h4;
    // Control and status bit positions
    localparam int CTL_ENABLE   = 0;
    localparam int CTL_PGERS    = 1;
    localparam int CTL_PGWRT    = 2;
    localparam int CTL_LOCK_ARM = 3;
    localparam int CTL_RWW_REEN = 4;
    localparam int CTL_SIG_ARM  = 5;
    localparam int CTL_RWW_BUSY = 6;
    // Pointer values for special reads
    localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
    localparam logic [15:0] Z_LOCK      = 16'h0001;
    localparam logic [15:0] Z_FUSE_EXT  = 16'h0002;
    localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
    localparam logic [15:0] Z_SIG_ID0   = 16'h0000;
    localparam logic [15:0] Z_SIG_CAL   = 16'h0001;
    localparam logic [15:0] Z_SIG_ID1   = 16'h0002;
    localparam logic [15:0] Z_SIG_ID2   = 16'h0004;
    localparam logic [15:0] Z_SER_FIRST = 16'h000E;
    localparam logic [15:0] Z_SER_GAP   = 16'h0014;
    localparam logic [15:0] Z_SER_LAST  = 16'h0017;
    // Read-back fill and reset values
    localparam logic [7:0]  READ_UNUSED = 8'hFF;
    localparam logic [1:0]  LOCK_PAD    = 2'h3;
    localparam logic [4:0]  EXT_PAD     = 5'h1F;
    localparam logic [5:0]  LOCK_RESET  = 6'h3F;
    localparam logic [15:0] BOOT_NOREAD_AREA_BASE_WORD = 16'hF000;
    // Host command port offsets and fields
    localparam logic [3:0] HREG_ZPTR   = 4'h0;
    localparam logic [3:0] HREG_DATA   = 4'h1;
    localparam logic [3:0] HREG_CTL    = 4'h2;
    localparam logic [3:0] HREG_ISSUE  = 4'h3;
    localparam logic [3:0] HREG_RESULT = 4'h4;
    localparam int ISSUE_LPM   = 0;
    localparam int ISSUE_SPM   = 1;
    localparam int RES_VALID   = 8;
    localparam int RES_REFUSED = 9;

    typedef enum logic [3:0] {
        FLSR_IDLE      = 4'b0000,
        FLSR_ARM_LOAD  = 4'b0001,
        FLSR_ARM_ERASE = 4'b0010,
        FLSR_ARM_WRITE = 4'b0011,
        FLSR_ARM_LOCK  = 4'b0100,
        FLSR_ARM_SIG   = 4'b0101,
        FLSR_ARM_RWWEN = 4'b0110,
        FLSR_BUSY_PAGE = 4'b0111,
        FLSR_BUSY_LOCK = 4'b1000
    } flsr_mode_t;
endpackage

// File: include/flsr_if.sv
// Link between the CPU-side controller and the readout device
`timescale 1ns/100ps
interface flsr_if;
    logic        ctl_wr;
    logic [7:0]  ctl_wdata;
    logic [7:0]  ctl_rdata;
    logic        lpm_req;
    logic        spm_req;
    logic [15:0] zptr;
    logic [15:0] spm_data;
    logic        ee_pending;
    logic        lpm_valid;
    logic [7:0]  lpm_data;
    logic        fetch_req;
    logic [15:0] fetch_addr;
    logic        fetch_hold;

    modport dev (
        input  ctl_wr, ctl_wdata, lpm_req, spm_req, zptr, spm_data, ee_pending, fetch_req, fetch_addr,
        output ctl_rdata, lpm_valid, lpm_data, fetch_hold
    );
    modport host (
        output ctl_wr, ctl_wdata, lpm_req, spm_req, zptr, spm_data, ee_pending, fetch_req, fetch_addr,
        input  ctl_rdata, lpm_valid, lpm_data, fetch_hold
    );
endinterface

// File: design/flsr_device.sv
// Device end: control/status register, timed readout, self-timed programming
//
// Overview of operation
// - Armed lock read at pointer 1 returns protection
// - Arms clear after read or window timeout
// - Disarmed loads return ordinary flash bytes
// - Protection byte: boot locks 5..2, memory 1..0
// - Armed read at pointer 0 returns low fuse
// - Armed read at pointer 3 returns high fuse
// - Armed read at pointer 2 returns extended fuse
// - Programmed reads zero, unprogrammed reads one
// - Armed signature read returns row byte
// - Signature arm clears after read or timeout
// - Identification bytes at pointers 0, 2, 4
// - Oscillator calibration byte at pointer 1
// - Serial bytes at 0E-13 pair-swapped, 15-17 straight order
// - Reserved signature addresses carry no meaning
// - Erase, write, lock-write self-timed 3.7-4.5ms
// - Core reset does not abort programming
// - Only boot area fetchable during RWW page programming
// - Re-enable command flushes temporary page buffer
// - Busy flag holds until re-enable or page load succeeds
// - Software waits idle, masks interrupts, no EEPROM
// - Pending EEPROM write blocks arming entirely
// - Pointer bit 0 selects byte and readout
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/100ps
module flsr_device
    import flsr_pkg::*;
#(
    parameter int          PROG_CYCLES = flsr_pkg::PROG_CYC_MIN,
    parameter logic [7:0]  SIG_BYTE0   = 8'h5A,  // Arbitrary value
    parameter logic [7:0]  SIG_BYTE1   = 8'hA5,  // Arbitrary value
    parameter logic [7:0]  SIG_BYTE2   = 8'h3C,  // Arbitrary value
    parameter logic [7:0]  CAL_BYTE    = 8'h80,
    parameter logic [71:0] SERIAL      = 72'h88_7766_5544_3322_1100
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        core_reset_i,
    // Link to the controller
    flsr_if.dev              link,
    // Flash word at link.zptr[15:1], and fuse cells
    input  wire logic [15:0] flash_word_i,
    input  wire logic [7:0]  fuse_low_i,
    input  wire logic [7:0]  fuse_high_i,
    input  wire logic [2:0]  fuse_ext_i,
    // Status
    output logic [5:0]       lock_bits_o,
    output logic             page_buf_loaded_o,
    output logic             prog_busy_o
);
    import flsr_pkg::*;

    typedef struct packed {
        flsr_mode_t          mode;
        logic [2:0]          win;
        logic [TIMER_W-1:0]  timer;
        logic [5:1]          ctl_bits;
        logic                page_write;
        logic                halt_all;
        logic                rww_busy;
        logic [5:0]          lock;
        logic [5:0]          lock_data;
        logic                buf_loaded;
        logic [7:0]          status;
        logic                lpm_valid;
        logic [7:0]          lpm_data;
        logic                fetch_hold;
        logic                prog_busy;
    } flsr_dev_state_t;

    localparam flsr_dev_state_t DEV_RESET = '{
        mode: FLSR_IDLE, win: 3'h0, timer: '0, ctl_bits: 5'h00, page_write: 1'b0,
        halt_all: 1'b0, rww_busy: 1'b0, lock: LOCK_RESET, lock_data: LOCK_RESET,
        buf_loaded: 1'b0, status: 8'h00, lpm_valid: 1'b0, lpm_data: 8'h00, fetch_hold: 1'b0,
        prog_busy: 1'b0};

    flsr_dev_state_t st;
    flsr_dev_state_t next_st;

    function automatic flsr_mode_t decode_cmd(input logic [7:0] v);
        flsr_mode_t m;
        if (v[CTL_SIG_ARM]) m = FLSR_ARM_SIG;
        else if (v[CTL_LOCK_ARM]) m = FLSR_ARM_LOCK;
        else if (v[CTL_RWW_REEN]) m = FLSR_ARM_RWWEN;
        else if (v[CTL_PGWRT]) m = FLSR_ARM_WRITE;
        else if (v[CTL_PGERS]) m = FLSR_ARM_ERASE;
        else m = FLSR_ARM_LOAD;
        return m;
    endfunction

    // Whole pointer decodes; any other pointer reads all ones
    function automatic logic [7:0] fuse_lock_byte(input logic [15:0] z, input logic [5:0] lk);
        logic [7:0] b;
        unique case (z)
            Z_LOCK:      b = {LOCK_PAD, lk};
            Z_FUSE_LOW:  b = fuse_low_i;
            Z_FUSE_HIGH: b = fuse_high_i;
            Z_FUSE_EXT:  b = {EXT_PAD, fuse_ext_i};
            default:     b = READ_UNUSED;
        endcase
        return b;
    endfunction

    function automatic logic [7:0] sig_byte(input logic [15:0] z);
        logic [7:0]  b;
        logic [15:0] off;
        logic [3:0]  idx;
        off = z - Z_SER_FIRST;
        idx = 4'h0;
        b   = READ_UNUSED;
        if (z == Z_SIG_ID0) b = SIG_BYTE0;
        else if (z == Z_SIG_ID1) b = SIG_BYTE1;
        else if (z == Z_SIG_ID2) b = SIG_BYTE2;
        else if (z == Z_SIG_CAL) b = CAL_BYTE;
        else if (z >= Z_SER_FIRST && z <= Z_SER_LAST && z != Z_SER_GAP) begin
            // Pairs swapped below the gap, straight order above it
            if (z < Z_SER_GAP) idx = off[3:0] ^ 4'h1;
            else idx = off[3:0] - 4'h1;
            b = SERIAL[idx*8 +: 8];
        end
        return b;
    endfunction

    always_comb begin
        logic armed;
        logic busy;
        logic lpm_special;
        logic spm_taken;
        logic rww_target;
        logic timeout;
        armed       = 1'b0;
        busy        = 1'b0;
        lpm_special = 1'b0;
        spm_taken   = 1'b0;
        rww_target  = 1'b0;
        timeout     = 1'b0;
        next_st     = st;
        next_st.lpm_valid = 1'b0;

        busy  = (st.mode == FLSR_BUSY_PAGE) || (st.mode == FLSR_BUSY_LOCK);
        armed = (st.mode != FLSR_IDLE) && !busy;
        rww_target = {1'b0, link.zptr[15:1]} < BOOT_NOREAD_AREA_BASE_WORD;
        lpm_special = link.lpm_req && (st.win < LPM_WINDOW) &&
                      ((st.mode == FLSR_ARM_LOCK) || (st.mode == FLSR_ARM_SIG));
        spm_taken = link.spm_req && armed && (st.win < SPM_WINDOW) && (st.mode != FLSR_ARM_SIG);
        // Lock arm keeps the longer store window; signature arm has only the load window
        timeout = (st.mode == FLSR_ARM_SIG) ? (st.win == LPM_WINDOW - 3'h1)
                                            : (st.win == SPM_WINDOW - 3'h1);
        if (armed) begin
            next_st.win = st.win + 3'h1;
        end

        if (link.lpm_req) begin
            next_st.lpm_valid = 1'b1;
            if (lpm_special && st.mode == FLSR_ARM_LOCK) begin
                next_st.lpm_data = fuse_lock_byte(link.zptr, st.lock);
            end else if (lpm_special) begin
                next_st.lpm_data = sig_byte(link.zptr);
            end else if (link.zptr[0]) begin
                next_st.lpm_data = flash_word_i[15:8];
            end else begin
                next_st.lpm_data = flash_word_i[7:0];
            end
        end

        if (lpm_special) begin
            next_st.mode     = FLSR_IDLE;
            next_st.ctl_bits = 5'h00;
        end else if (spm_taken) begin
            unique case (st.mode)
                FLSR_ARM_LOAD: begin
                    next_st.buf_loaded = 1'b1;
                    next_st.rww_busy   = 1'b0;
                    next_st.mode       = FLSR_IDLE;
                    next_st.ctl_bits   = 5'h00;
                end
                FLSR_ARM_ERASE, FLSR_ARM_WRITE: begin
                    next_st.mode       = FLSR_BUSY_PAGE;
                    next_st.timer      = '0;
                    next_st.page_write = (st.mode == FLSR_ARM_WRITE);
                    next_st.rww_busy   = st.rww_busy || rww_target;
                    next_st.halt_all   = !rww_target;
                end
                FLSR_ARM_LOCK: begin
                    next_st.mode      = FLSR_BUSY_LOCK;
                    next_st.timer     = '0;
                    next_st.lock_data = link.spm_data[5:0];
                end
                default: begin
                    next_st.rww_busy   = 1'b0;
                    next_st.buf_loaded = 1'b0;
                    next_st.mode       = FLSR_IDLE;
                    next_st.ctl_bits   = 5'h00;
                end
            endcase
        end else if (armed && timeout) begin
            next_st.mode     = FLSR_IDLE;
            next_st.ctl_bits = 5'h00;
        end

        if (busy) begin
            next_st.timer = st.timer + TIMER_W'(1);
            if (st.timer == TIMER_W'(PROG_CYCLES - 1)) begin
                next_st.mode     = FLSR_IDLE;
                next_st.ctl_bits = 5'h00;
                next_st.halt_all = 1'b0;
                if (st.mode == FLSR_BUSY_LOCK) begin
                    next_st.lock = st.lock & st.lock_data;
                end else if (st.page_write) begin
                    next_st.buf_loaded = 1'b0;
                end
            end
        end

        // Writes during programming or a pending EEPROM write are dropped
        if (link.ctl_wr && !busy && !link.ee_pending) begin
            next_st.win      = 3'h0;
            next_st.ctl_bits = link.ctl_wdata[5:1] & {5{link.ctl_wdata[CTL_ENABLE]}};
            next_st.mode     = link.ctl_wdata[CTL_ENABLE] ? decode_cmd(link.ctl_wdata) : FLSR_IDLE;
        end

        // Core reset clears control, programming runs on to completion
        if (core_reset_i) begin
            next_st.buf_loaded = 1'b0;
            next_st.lpm_valid  = 1'b0;
            if (!busy) begin
                next_st.mode     = FLSR_IDLE;
                next_st.ctl_bits = 5'h00;
            end
        end

        next_st.status = {1'b0, next_st.rww_busy, next_st.ctl_bits, next_st.mode != FLSR_IDLE};
        next_st.fetch_hold = link.fetch_req &&
                             (st.halt_all || (st.rww_busy && link.fetch_addr < BOOT_NOREAD_AREA_BASE_WORD));
        // Registered so the busy pin carries no decode glitches
        next_st.prog_busy = (next_st.mode == FLSR_BUSY_PAGE) || (next_st.mode == FLSR_BUSY_LOCK);
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= DEV_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign link.ctl_rdata  = st.status;
    assign link.lpm_valid  = st.lpm_valid;
    assign link.lpm_data   = st.lpm_data;
    assign link.fetch_hold = st.fetch_hold;
    assign lock_bits_o       = st.lock;
    assign page_buf_loaded_o = st.buf_loaded;
    assign prog_busy_o       = st.prog_busy;
endmodule

// File: design/flsr_host.sv
// Controller end: software command port driving the readout link
`timescale 1ns/100ps
module flsr_host
    import flsr_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // Software port
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [15:0]      reg_rdata_o,
    // Core side
    input  wire logic        ee_busy_i,
    input  wire logic        fetch_req_i,
    input  wire logic [15:0] fetch_addr_i,
    output logic             fetch_hold_o,
    // Link to the device
    flsr_if.host             link
);
    import flsr_pkg::*;

    typedef struct packed {
        logic        ctl_wr;
        logic [7:0]  ctl_wdata;
        logic        lpm_req;
        logic        spm_req;
        logic [15:0] zptr;
        logic [15:0] spm_data;
        logic        ee_pending;
        logic        fetch_req;
        logic [15:0] fetch_addr;
        logic [15:0] rdata;
        logic [7:0]  result;
        logic        result_valid;
        logic        refused;
    } flsr_host_state_t;

    flsr_host_state_t st;
    flsr_host_state_t next_st;

    always_comb begin
        logic wr_ok;
        wr_ok   = 1'b0;
        next_st = st;
        next_st.ctl_wr     = 1'b0;
        next_st.lpm_req    = 1'b0;
        next_st.spm_req    = 1'b0;
        next_st.ee_pending = ee_busy_i;
        next_st.fetch_req  = fetch_req_i;
        next_st.fetch_addr = fetch_addr_i;
        next_st.rdata      = 16'h0000;
        // Status lags a link write by one cycle, so a write in flight counts as busy
        wr_ok = !link.ctl_rdata[CTL_ENABLE] && !st.ctl_wr && !ee_busy_i && !st.ee_pending;

        if (reg_rd_i) begin
            unique case (reg_addr_i)
                HREG_ZPTR:   next_st.rdata = st.zptr;
                HREG_DATA:   next_st.rdata = st.spm_data;
                HREG_CTL:    next_st.rdata = {8'h00, link.ctl_rdata};
                HREG_RESULT: next_st.rdata = {6'h00, st.refused, st.result_valid, st.result};
                default:     next_st.rdata = 16'h0000;
            endcase
            if (reg_addr_i == HREG_RESULT) begin
                next_st.result_valid = 1'b0;
                next_st.refused      = 1'b0;
            end
        end

        if (reg_wr_i) begin
            unique case (reg_addr_i)
                HREG_ZPTR: next_st.zptr = reg_wdata_i;
                HREG_DATA: next_st.spm_data = reg_wdata_i;
                HREG_CTL: begin
                    if (wr_ok) begin
                        next_st.ctl_wr    = 1'b1;
                        next_st.ctl_wdata = reg_wdata_i[7:0];
                    end else begin
                        next_st.refused = 1'b1;
                    end
                end
                HREG_ISSUE: begin
                    next_st.lpm_req = reg_wdata_i[ISSUE_LPM];
                    next_st.spm_req = reg_wdata_i[ISSUE_SPM] && !reg_wdata_i[ISSUE_LPM];
                end
                default: ;
            endcase
        end

        // A result landing in the read cycle survives the clear
        if (link.lpm_valid) begin
            next_st.result       = link.lpm_data;
            next_st.result_valid = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.ctl_wr     = st.ctl_wr;
    assign link.ctl_wdata  = st.ctl_wdata;
    assign link.lpm_req    = st.lpm_req;
    assign link.spm_req    = st.spm_req;
    assign link.zptr       = st.zptr;
    assign link.spm_data   = st.spm_data;
    assign link.ee_pending = st.ee_pending;
    assign link.fetch_req  = st.fetch_req;
    assign link.fetch_addr = st.fetch_addr;
    assign reg_rdata_o     = st.rdata;
    assign fetch_hold_o    = link.fetch_hold;
endmodule

// File: testbench/flsr_asserts.sv
// Concurrent checks on the link between controller and readout device
`timescale 1ns/100ps
module flsr_asserts
    import flsr_pkg::*;
#(
    parameter int PROG_CYCLES = 12
) (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        lpm_req,
    input wire logic        spm_req,
    input wire logic [15:0] zptr,
    input wire logic [7:0]  ctl_rdata,
    input wire logic        ee_pending,
    input wire logic        lpm_valid,
    input wire logic [7:0]  lpm_data,
    input wire logic        fetch_req,
    input wire logic        fetch_hold
);
    // Margin around the self-timed end so a one-cycle launch offset is tolerated
    localparam int P_LO = PROG_CYCLES - 2;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    load_answer_a: assert property (lpm_req |=> lpm_valid)
        else $error("load not answered in the next cycle");
    answer_cause_a: assert property (lpm_valid |-> $past(lpm_req))
        else $error("load answer without a load");
    sig_release_a: assert property (lpm_valid |-> !ctl_rdata[5])
        else $error("signature arm still set after load");
    sig_timeout_a: assert property ($rose(ctl_rdata[5]) |-> ##[1:4] !ctl_rdata[5])
        else $error("signature arm did not time out");
    lock_pad_a: assert property (lpm_req && zptr == Z_LOCK && ctl_rdata == 8'h09 |=> lpm_data[7:6] == 2'b11)
        else $error("protection byte unused bits not one");
    ext_pad_a: assert property (lpm_req && zptr == Z_FUSE_EXT && ctl_rdata == 8'h09 |=> lpm_data[7:3] == EXT_PAD)
        else $error("extended fuse unused bits not one");
    ee_block_a: assert property (ee_pending |=> !$rose(ctl_rdata[0]))
        else $error("arming accepted during data-memory write");
    busy_len_a: assert property ($rose(ctl_rdata[6]) |-> ##P_LO ctl_rdata[0] ##[1:4] !ctl_rdata[0])
        else $error("programming time outside the window");
    rww_clear_a: assert property ($fell(ctl_rdata[6]) |-> $past(spm_req))
        else $error("busy flag cleared without a store");
    hold_cause_a: assert property (fetch_hold |-> $past(fetch_req) && ($past(ctl_rdata[0]) || $past(ctl_rdata[6])))
        else $error("fetch held outside programming");

    lock_read_c: cover property (lpm_req && zptr == Z_LOCK && ctl_rdata == 8'h09);
    sig_arm_c: cover property ($rose(ctl_rdata[5]));
    rww_done_c: cover property ($fell(ctl_rdata[6]));
endmodule

// File: testbench/tb_fuse_lock_signature_readout.sv
// Self-checking bench for the fuse, lock and signature readout pair
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb_fuse_lock_signature_readout;
    import flsr_pkg::*;
    localparam int          PROG = 12;
    localparam logic [71:0] SER  = 72'h99_8877_6655_4433_2211;
    logic        clock_i      = 1'b0;
    logic        rst_n_i      = 1'b0;
    logic        core_reset_i = 1'b0;
    logic [3:0]  reg_addr_i   = 4'h0;
    logic [15:0] reg_wdata_i  = 16'h0000;
    logic        reg_wr_i     = 1'b0;
    logic        reg_rd_i     = 1'b0;
    logic        ee_busy_i    = 1'b0;
    logic        fetch_req_i  = 1'b0;
    logic [15:0] fetch_addr_i = 16'h0000;
    logic [15:0] reg_rdata_o;
    logic        fetch_hold_o;
    logic [15:0] flash_word_i;
    logic [5:0]  lock_bits_o;
    logic        page_buf_loaded_o;
    logic        prog_busy_o;
    logic [7:0]  fuse_low_i   = 8'h3A;
    logic [7:0]  fuse_high_i  = 8'hC5;
    logic [2:0]  fuse_ext_i   = 3'h5;
    logic [15:0] d;
    logic [15:0] fz [4] = '{Z_FUSE_LOW, Z_LOCK, Z_FUSE_EXT, Z_FUSE_HIGH};
    logic [7:0]  fx [4] = '{8'h3A, 8'hFF, 8'hFD, 8'hC5};
    int          error_cnt = 0;
    int          n_tests   = 0;

    flsr_if link ();
    // High byte fixed, low byte tracks the pointer so byte select is visible
    assign flash_word_i = {8'hC3, link.zptr[8:1]};
    always #25 clock_i = ~clock_i;

    flsr_host flsr_host_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .ee_busy_i(ee_busy_i), .fetch_req_i(fetch_req_i), .fetch_addr_i(fetch_addr_i),
        .fetch_hold_o(fetch_hold_o), .link(link));
    // Identity bytes are arbitrary
    flsr_device #(.PROG_CYCLES(PROG), .SIG_BYTE0(8'h5A), .SIG_BYTE1(8'hA5), .SIG_BYTE2(8'h3C),
        .CAL_BYTE(8'h80), .SERIAL(SER)) flsr_device_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .core_reset_i(core_reset_i), .link(link), .flash_word_i(flash_word_i), .fuse_low_i(fuse_low_i),
        .fuse_high_i(fuse_high_i), .fuse_ext_i(fuse_ext_i), .lock_bits_o(lock_bits_o),
        .page_buf_loaded_o(page_buf_loaded_o), .prog_busy_o(prog_busy_o));
    flsr_asserts #(.PROG_CYCLES(PROG)) flsr_asserts_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .lpm_req(link.lpm_req), .spm_req(link.spm_req), .zptr(link.zptr), .ctl_rdata(link.ctl_rdata),
        .ee_pending(link.ee_pending), .lpm_valid(link.lpm_valid), .lpm_data(link.lpm_data),
        .fetch_req(link.fetch_req), .fetch_hold(link.fetch_hold));

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clock_i);
        reg_addr_i  <= a;
        reg_wdata_i <= v;
        reg_wr_i    <= 1'b1;
        @(posedge clock_i);
        reg_wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clock_i);
        reg_rd_i   <= 1'b0;
        #1 v = reg_rdata_o;
    endtask
    // Result flag lands two cycles after the issue strobe
    task automatic lpm(output logic [15:0] v);
        wr(HREG_ISSUE, 16'h0001);
        @(posedge clock_i);
        rd(HREG_RESULT, v);
    endtask
    task automatic sread(input logic [7:0] arm, input logic [15:0] z, output logic [15:0] v);
        wr(HREG_ZPTR, z);
        wr(HREG_CTL, {8'h00, arm});
        lpm(v);
    endtask
    task automatic spm(input logic [7:0] cmd);
        wr(HREG_CTL, {8'h00, cmd});
        wr(HREG_ISSUE, 16'h0002);
    endtask
    task automatic fetch(input logic [15:0] a, input logic ex);
        @(posedge clock_i);
        fetch_req_i  <= 1'b1;
        fetch_addr_i <= a;
        @(posedge clock_i);
        fetch_req_i  <= 1'b0;
        // Hold comes back one cycle after the request crosses the link
        @(posedge clock_i);
        #1 `CHECK("fetch_hold", ex, fetch_hold_o)
    endtask
    function automatic logic [7:0] sig_exp(input int z);
        case (z)
            0: return 8'h5A;
            1: return 8'h80;
            2: return 8'hA5;
            4: return 8'h3C;
            14, 15, 16, 17, 18, 19: return SER[8 * ((z - 14) ^ 1) +: 8];
            21, 22, 23: return SER[8 * (z - 15) +: 8];
            default: return READ_UNUSED;
        endcase
    endfunction
    task automatic summarize();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(HREG_CTL, d);
        `CHECK("status_reset", 16'h0000, d)
        `CHECK("lock_reset", LOCK_RESET, lock_bits_o)
        rd(4'hF, d);
        `CHECK("unmapped", 16'h0000, d)
        for (int i = 0; i < 4; i++) begin
            sread(8'h09, fz[i], d);
            `CHECK("fuse_lock", {8'h01, fx[i]}, d)
        end
        lpm(d);
        `CHECK("second_load", 16'h01C3, d)
        sread(8'h00, Z_LOCK, d);
        `CHECK("disarmed", 16'h01C3, d)
        for (int z = 0; z < 24; z++) begin
            sread(8'h21, z[15:0], d);
            `CHECK("signature", {8'h01, sig_exp(z)}, d)
        end
        foreach (fx[i]) begin
            if (i < 2) begin
                wr(HREG_ZPTR, 16'h0000);
                wr(HREG_CTL, i == 0 ? 16'h0021 : 16'h0009);
                repeat (6) @(posedge clock_i);
                lpm(d);
                `CHECK("arm_timeout", 16'h0100, d)
            end
        end
        @(posedge clock_i);
        ee_busy_i <= 1'b1;
        sread(8'h09, Z_LOCK, d);
        `CHECK("ee_blocked", 16'h03C3, d)
        ee_busy_i <= 1'b0;
        wr(HREG_DATA, 16'h00ED);
        spm(8'h09);
        @(posedge clock_i);
        core_reset_i <= 1'b1;
        @(posedge clock_i);
        core_reset_i <= 1'b0;
        #1 `CHECK("busy_after_core_reset", 1'b1, prog_busy_o)
        repeat (PROG) @(posedge clock_i);
        #1 `CHECK("lock_written", 6'h2D, lock_bits_o)
        sread(8'h09, Z_LOCK, d);
        `CHECK("lock_read", 16'h01ED, d)
        wr(HREG_DATA, 16'h1234);
        spm(8'h01);
        @(posedge clock_i);
        #1 `CHECK("buffer_loaded", 1'b1, page_buf_loaded_o)
        wr(HREG_ZPTR, 16'h0100);
        spm(8'h03);
        rd(HREG_CTL, d);
        `CHECK("erase_status", 16'h0043, d)
        fetch(16'h0010, 1'b1);
        fetch(16'hF000, 1'b0);
        repeat (PROG) @(posedge clock_i);
        rd(HREG_CTL, d);
        `CHECK("erase_done", 16'h0040, d)
        fetch(16'h0010, 1'b1);
        spm(8'h11);
        @(posedge clock_i);
        rd(HREG_CTL, d);
        `CHECK("reenabled", 16'h0000, d)
        `CHECK("buffer_flushed", 1'b0, page_buf_loaded_o)
        fetch(16'h0010, 1'b0);
        spm(8'h01);
        spm(8'h05);
        repeat (PROG) @(posedge clock_i);
        rd(HREG_CTL, d);
        `CHECK("write_done", 16'h0040, d)
        `CHECK("buffer_written", 1'b0, page_buf_loaded_o)
        fuse_low_i <= 8'hA3;
        sread(8'h09, Z_FUSE_LOW, d);
        `CHECK("fuse_low_new", 16'h01A3, d)
        summarize();
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clock_i);
        error_cnt++;
        summarize();
    end
endmodule
